// ===== tsc_pkg.sv
// Shared constants, carriers and arithmetic for the transmit sum chain block
package tsc_pkg;

  // Data widths
  localparam int IN_W    = 21;
  localparam int SUM_W   = 26;
  localparam int OUT_W   = 18;
  localparam int NCHAIN  = 4;
  localparam int ACC_W   = 58;
  localparam int RES_W   = 32;
  localparam int CNT_W   = 21;
  localparam int DLY_W   = 9;
  localparam int HALF_W  = 16;
  localparam int RES_LSB = ACC_W - RES_W;

  // Scale window and rounding
  localparam logic [3:0]        SCALE_MAX = 4'h8;
  localparam logic signed [17:0] SAT_POS  = 18'h1FFFF;
  localparam logic signed [17:0] SAT_NEG  = 18'h20000;
  localparam logic [17:0]        ALL_ONES = 18'h3FFFF;

  // Meter timing
  localparam logic [9:0]  DLY_EXTRA = 10'h002;
  localparam logic [31:0] RESULT_RST = 32'h0000_0000;

  // Buffering
  localparam int FIFO_DEPTH = 16;

  // Sync source codes, 0 to 3 are the sync pins
  localparam logic [2:0] SYNC_TC  = 3'h4;
  localparam logic [2:0] SYNC_SW  = 3'h5;
  localparam logic [2:0] SYNC_OFF = 3'h6;
  localparam logic [2:0] SYNC_ON  = 3'h7;

  typedef struct packed {
    logic signed [IN_W-1:0] i;
    logic signed [IN_W-1:0] q;
  } tsc_ch_t;

  typedef struct packed {
    logic signed [OUT_W-1:0] i;
    logic signed [OUT_W-1:0] q;
  } tsc_smp_t;

  typedef tsc_smp_t [NCHAIN-1:0] tsc_frame_t;

  typedef enum {MS_IDLE, MS_DELAY, MS_RUN} tsc_mstate_t;

  // Sign extension of a channel word to the chain width
  function automatic logic signed [SUM_W-1:0] tsc_sext(input logic signed [IN_W-1:0] x);
    return {{(SUM_W-IN_W){x[IN_W-1]}}, x};
  endfunction : tsc_sext

  // Pick an 18-bit window and hard-limit instead of wrapping
  function automatic logic signed [17:0] tsc_scale_sat(input logic signed [25:0] s, input logic [3:0] code);
    logic [3:0]         c;
    logic signed [25:0] sh;
    c  = (code > SCALE_MAX) ? SCALE_MAX : code;
    sh = s >>> (SCALE_MAX - c);
    if (sh[25:17] != {9{sh[25]}}) begin
      return sh[25] ? SAT_NEG : SAT_POS;
    end
    return sh[17:0];
  endfunction : tsc_scale_sat

  // Round to 18/16/14/12 bits, MSB justified, low bits zeroed
  function automatic logic signed [17:0] tsc_round(input logic signed [17:0] x, input logic [1:0] r);
    logic [4:0]         drop;
    logic [17:0]        mask;
    logic signed [18:0] t;
    drop = {2'b00, r, 1'b0};
    mask = ALL_ONES << drop;
    t    = {x[17], x} + ((drop == 5'h00) ? 19'h00000 : (19'h00001 << (drop - 5'h01)));
    if (t[18] != t[17]) begin
      return SAT_POS & mask;
    end
    return t[17:0] & mask;
  endfunction : tsc_round

endpackage : tsc_pkg

// ===== tsc_fifo.sv
// Sample FIFO with a registered output stage
`timescale 1ns/1ps
module tsc_fifo import tsc_pkg::*; #(
  parameter int WIDTH = 144,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int LVL_W = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  // Write side
  input  wire logic             wr_valid_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  output logic                  wr_ready_o,
  output logic [LVL_W-1:0]      level_o,
  // Read side
  output logic                  rd_valid_o,
  output logic [WIDTH-1:0]      rd_data_o,
  input  wire logic             rd_ready_i
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;

  wire push = wr_valid_i & wr_ready_o;
  wire pop  = (level_o != '0) & (~rd_valid_o | rd_ready_i);

  // Full and empty come straight from the stored level
  assign wr_ready_o = (level_o != LVL_W'(DEPTH));

  // Storage has no reset, only pointers, level, valid flag and output data do
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= wr_data_i;
    end
  end

  // Pointers, level and output register
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      level_o    <= '0;
      rd_valid_o <= 1'b0;
      rd_data_o  <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + PTR_W'(1);
      if (pop) rd_ptr <= rd_ptr + PTR_W'(1);
      level_o <= level_o + LVL_W'(push) - LVL_W'(pop);
      if (pop) begin
        rd_data_o  <= mem[rd_ptr];
        rd_valid_o <= 1'b1;
      end else if (rd_ready_i) begin
        rd_valid_o <= 1'b0;
      end
    end
  end

endmodule : tsc_fifo

// ===== tsc_meter.sv
// Composite RMS power meter for one sum chain
`timescale 1ns/1ps
module tsc_meter import tsc_pkg::*; (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  // Samples and sync
  input  wire logic             tick_i,
  input  tsc_smp_t              smp_i,
  input  wire logic             sync_i,
  // Settings
  input  wire logic [CNT_W-1:0] integ_len_i,
  input  wire logic [CNT_W-1:0] repeat_i,
  input  wire logic [DLY_W-1:0] start_delay_i,
  // Result
  output logic [RES_W-1:0]      result_o,
  output logic                  done_o
);
  tsc_mstate_t      state;
  logic             sync_d;
  logic [9:0]       dcnt;
  logic [9:0]       dticks;
  logic [CNT_W-1:0] ic;
  logic [CNT_W-1:0] cnt;
  logic             integ;
  logic [ACC_W-1:0] acc;

  // Squares and sum of squares
  wire signed [35:0] sq_i      = smp_i.i * smp_i.i;
  wire signed [35:0] sq_q      = smp_i.q * smp_i.q;
  wire [ACC_W-1:0]   power     = ACC_W'(unsigned'(sq_i)) + ACC_W'(unsigned'(sq_q));
  // Interval start clears the integrator instead of adding to it
  wire               sync_rise = sync_i & ~sync_d;
  wire               first     = (ic == '0);
  wire               integ_now = first | integ;
  wire [ACC_W-1:0]   next_acc  = (first ? '0 : acc) + power;
  wire [CNT_W-1:0]   next_cnt  = first ? CNT_W'(1) : cnt + CNT_W'(1);
  wire               hit       = integ_now & (next_cnt == integ_len_i);
  wire [CNT_W-1:0]   next_ic   = (ic >= repeat_i) ? '0 : ic + CNT_W'(1);

  // Sync edge, delay and measurement sequencing; a fresh sync always wins
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state    <= MS_IDLE;
      sync_d   <= 1'b0;
      dcnt     <= '0;
      dticks   <= '0;
      ic       <= '0;
      cnt      <= '0;
      integ    <= 1'b0;
      acc      <= '0;
      result_o <= RESULT_RST;
      done_o   <= 1'b0;
    end else begin
      sync_d <= sync_i;
      done_o <= 1'b0;
      if (sync_rise) begin
        state  <= MS_DELAY;
        dcnt   <= 10'(start_delay_i) + DLY_EXTRA;
        dticks <= '0;
      end else if (tick_i) begin
        case (state)
          MS_DELAY: begin
            dticks <= dticks + 10'h001;
            if (dcnt == 10'h001) begin
              state <= MS_RUN;
              ic    <= '0;
              integ <= 1'b0;
            end else begin
              dcnt <= dcnt - 10'h001;
            end
          end
          MS_RUN: begin
            ic <= next_ic;
            if (integ_now) begin
              acc   <= next_acc;
              cnt   <= next_cnt;
              integ <= ~hit;
            end
            if (hit) begin
              result_o <= next_acc[ACC_W-1:RES_LSB];
              done_o   <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  delay_length_a: assert property ($rose(state == MS_RUN) |-> dticks == 10'(start_delay_i) + DLY_EXTRA)
    else $error("integration did not start delay plus two samples after sync");
  interval_wrap_a: assert property (tick_i && !sync_rise && state == MS_RUN && ic == repeat_i |=> ic == '0)
    else $error("interval counter did not wrap at programmed value");
  integ_count_a: assert property (done_o |-> cnt == integ_len_i)
    else $error("result taken at wrong integration count");
  acc_clear_a: assert property (tick_i && !sync_rise && state == MS_RUN && first |=> acc == $past(power))
    else $error("integrator not cleared at interval start");
  result_hold_a: assert property (!done_o |-> $stable(result_o))
    else $error("result changed without a completed integration");
  result_take_a: assert property (done_o |-> result_o == $past(next_acc[ACC_W-1:RES_LSB]))
    else $error("result is not the upper integrator bits");

  meas_done_c: cover property (done_o ##[1:1000] done_o);
  sync_restart_c: cover property (state == MS_RUN ##1 state == MS_DELAY);

endmodule : tsc_meter

// ===== tsc_top.sv
// Transmit sum chains, scale and round, output FIFO and composite power meters
`timescale 1ns/1ps
// Contract
// - Channel words are 21 bits; chain partial sums are 26 bits wide.
// - Partial sums pass channel to channel; the last holds the composite.
// - Path A four-bit enable adds its I/Q to any set of chains.
// - Path B four-bit enable acts likewise, only in dual-path mode.
// - Per-chain window code picks 18 of 26 bits, bits 25:8 down to 17:0.
// - Windowed value saturates rather than wraps, and is rounded afterwards.
// - Common rounding code selects 18, 16, 14 or 12 output bits.
// - Rounded result stays MSB-justified with lower bits forced to zero.
// - Four meters, one per chain, each with own counters and sync choice.
// - Meter squares I and Q, adds, accumulates into 58 bits.
// - Integration lasts the programmed 21-bit count of samples.
// - Interval repeats every programmed value plus one samples.
// - Sync starts delay; integration begins after delay plus two samples.
// - At integration end the upper 32 accumulator bits become the result.
// - Result reads as low half bits 15:0 and high half 31:16.
// - Integration and interval settings come as 16-bit low, 5-bit high.
// - Three-bit sync select per meter; selected sync restarts its delay.
// - Sync codes: 0-3 pins, 4 counter end, 5 one-shot, 6 off, 7 on.
// - Sync pins are sampled on the rising clock edge.
module tsc_top import tsc_pkg::*; #(
  parameter int NUM_CH = 12,
  parameter int DEPTH  = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic               ref_clk_i,
  input  wire logic               reset_i,
  // Channel mixer outputs
  input  wire logic               ch_valid_i,
  input  tsc_ch_t                 ch_a_i               [NUM_CH],
  input  tsc_ch_t                 ch_b_i               [NUM_CH],
  output logic                    ch_ready_o,
  // Chain enables and mode
  input  wire logic [3:0]         path_a_sum_en_i      [NUM_CH],
  input  wire logic [3:0]         path_b_sum_en_i      [NUM_CH],
  input  wire logic               dual_path_mode_i,
  // Scale and round
  input  wire logic [3:0]         scale_sel_i          [NCHAIN],
  input  wire logic [1:0]         round_sel_i,
  // Composite output stream
  output logic                    out_valid_o,
  output tsc_frame_t              out_data_o,
  input  wire logic               out_ready_i,
  // Sync sources
  input  wire logic [3:0]         tx_sync_pin_i,
  input  wire logic               sync_count_tc_i,
  input  wire logic               sync_oneshot_i,
  // Meter settings
  input  wire logic [2:0]         meter_sync_sel_i     [NCHAIN],
  input  wire logic [DLY_W-1:0]   meter_start_delay_i  [NCHAIN],
  input  wire logic [HALF_W-1:0]  meter_integ_len_low_i  [NCHAIN],
  input  wire logic [4:0]         meter_integ_len_high_i [NCHAIN],
  input  wire logic [HALF_W-1:0]  meter_repeat_low_i   [NCHAIN],
  input  wire logic [4:0]         meter_repeat_high_i  [NCHAIN],
  // Meter results
  output logic [HALF_W-1:0]       meter_result_low_o   [NCHAIN],
  output logic [HALF_W-1:0]       meter_result_high_o  [NCHAIN],
  output logic [NCHAIN-1:0]       meter_done_o
);
  localparam int LVL_W = $clog2(DEPTH + 1);

  logic signed [SUM_W-1:0] next_sum_i [NCHAIN];
  logic signed [SUM_W-1:0] next_sum_q [NCHAIN];
  logic signed [SUM_W-1:0] sum_i      [NCHAIN];
  logic signed [SUM_W-1:0] sum_q      [NCHAIN];
  logic                    v1;
  logic                    v2;
  tsc_frame_t              next_frame;
  tsc_frame_t              frame;
  logic [LVL_W-1:0]        fifo_level;
  logic                    fifo_wr_ready;
  logic [3:0]              sync_meta;
  logic [3:0]              sync_pin;
  logic [NCHAIN-1:0]       meter_sync;
  logic [RES_W-1:0]        meter_result [NCHAIN];
  logic                    no_contrib;

  wire fire = ch_valid_i & ch_ready_o;

  // Daisy chain: each channel adds its enabled paths onto the running sum
  always_comb begin
    no_contrib = 1'b1;
    for (int c = 0; c < NCHAIN; c++) begin
      next_sum_i[c] = '0;
      next_sum_q[c] = '0;
      for (int ch = 0; ch < NUM_CH; ch++) begin
        if (path_a_sum_en_i[ch][c]) begin
          next_sum_i[c] = next_sum_i[c] + tsc_sext(ch_a_i[ch].i);
          next_sum_q[c] = next_sum_q[c] + tsc_sext(ch_a_i[ch].q);
          no_contrib    = 1'b0;
        end
        if (dual_path_mode_i && path_b_sum_en_i[ch][c]) begin
          next_sum_i[c] = next_sum_i[c] + tsc_sext(ch_b_i[ch].i);
          next_sum_q[c] = next_sum_q[c] + tsc_sext(ch_b_i[ch].q);
          no_contrib    = 1'b0;
        end
      end
    end
  end

  // Window select, hard limit, then round, per chain and rail
  for (genvar c = 0; c < NCHAIN; c++) begin : g_fmt
    assign next_frame[c].i = tsc_round(tsc_scale_sat(sum_i[c], scale_sel_i[c]), round_sel_i);
    assign next_frame[c].q = tsc_round(tsc_scale_sat(sum_q[c], scale_sel_i[c]), round_sel_i);
  end

  // Two-stage pipeline, always moving; the FIFO absorbs stalls
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      v1    <= 1'b0;
      v2    <= 1'b0;
      frame <= '0;
      for (int c = 0; c < NCHAIN; c++) begin
        sum_i[c] <= '0;
        sum_q[c] <= '0;
      end
    end else begin
      v1 <= fire;
      v2 <= v1;
      if (fire) begin
        sum_i <= next_sum_i;
        sum_q <= next_sum_q;
      end
      if (v1) frame <= next_frame;
    end
  end

  // Ready counts words in flight so the pipeline can never overrun the FIFO
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ch_ready_o <= 1'b0;
    end else begin
      ch_ready_o <= (32'(fifo_level) + 32'(v2) + 32'(v1) + 32'(fire)) < 32'(DEPTH);
    end
  end

  tsc_fifo #(
    .WIDTH ($bits(tsc_frame_t)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .ref_clk_i  (ref_clk_i),
    .reset_i    (reset_i),
    .wr_valid_i (v2),
    .wr_data_i  (frame),
    .wr_ready_o (fifo_wr_ready),
    .level_o    (fifo_level),
    .rd_valid_o (out_valid_o),
    .rd_data_o  (out_data_o),
    .rd_ready_i (out_ready_i)
  );

  // Sync pins cross in through two flops before any selection
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync_meta <= '0;
      sync_pin  <= '0;
    end else begin
      sync_meta <= tx_sync_pin_i;
      sync_pin  <= sync_meta;
    end
  end

  // Per-meter sync source selection and the meters themselves
  for (genvar c = 0; c < NCHAIN; c++) begin : g_meter
    assign meter_sync[c] = (meter_sync_sel_i[c] == SYNC_TC)  ? sync_count_tc_i :
                           (meter_sync_sel_i[c] == SYNC_SW)  ? sync_oneshot_i :
                           (meter_sync_sel_i[c] == SYNC_OFF) ? 1'b0 :
                           (meter_sync_sel_i[c] == SYNC_ON)  ? 1'b1 :
                           sync_pin[meter_sync_sel_i[c][1:0]];

    tsc_meter u_meter (
      .ref_clk_i     (ref_clk_i),
      .reset_i       (reset_i),
      .tick_i        (v2),
      .smp_i         (frame[c]),
      .sync_i        (meter_sync[c]),
      .integ_len_i   ({meter_integ_len_high_i[c], meter_integ_len_low_i[c]}),
      .repeat_i      ({meter_repeat_high_i[c], meter_repeat_low_i[c]}),
      .start_delay_i (meter_start_delay_i[c]),
      .result_o      (meter_result[c]),
      .done_o        (meter_done_o[c])
    );

    assign meter_result_low_o[c]  = meter_result[c][HALF_W-1:0];
    assign meter_result_high_o[c] = meter_result[c][RES_W-1:HALF_W];
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  none_added_a: assert property (fire && no_contrib |=> sum_i[0] == '0 && sum_q[3] == '0)
    else $error("chain sum nonzero with no enabled contribution");
  window_pick_a: assert property (v1 && scale_sel_i[0] == SCALE_MAX && round_sel_i == 2'b00
                                  && sum_i[0][25:17] == {9{sum_i[0][17]}} |=> frame[0].i == $past(sum_i[0][17:0]))
    else $error("bottom window does not pass bits 17 to 0");
  sign_keep_a: assert property (v1 && !sum_i[1][25] |=> !frame[1].i[17])
    else $error("positive sum wrapped negative");
  low_zero_a: assert property (v2 && round_sel_i == 2'b11 |-> frame[2].q[5:0] == 6'h00 && frame[0].i[5:0] == 6'h00)
    else $error("bits below rounded width not zero");
  sync_off_a: assert property (meter_sync_sel_i[1] == SYNC_OFF |-> !meter_sync[1])
    else $error("sync code for never active produced a sync");
  no_overrun_a: assert property (v2 |-> fifo_wr_ready)
    else $error("composite sample arrived with FIFO full");

  fifo_full_c: cover property (!ch_ready_o && ch_valid_i && !out_ready_i);
  saturate_c: cover property (v2 && frame[0].i == SAT_POS);
  all_meters_c: cover property (meter_done_o == 4'hF);

endmodule : tsc_top

// ===== tsc_sink_model.sv
// Output port model that takes composite words and can stall
`timescale 1ns/1ps
module tsc_sink_model import tsc_pkg::*; (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  // Composite stream
  input  wire logic out_valid_i,
  input  tsc_frame_t out_data_i,
  output logic       out_ready_o,
  // Bench side
  input  wire logic stall_i,
  output logic       take_o,
  output tsc_frame_t word_o
);
  // Ready is registered, so a stall lands one edge after it is asked for
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_ready_o <= 1'b0;
      take_o      <= 1'b0;
      word_o      <= '0;
    end else begin
      out_ready_o <= !stall_i;
      take_o      <= out_valid_i && out_ready_o;
      if (out_valid_i && out_ready_o) word_o <= out_data_i;
    end
  end
endmodule : tsc_sink_model

// ===== test_tx_sum_chain_scale_power_meter.sv
// Self-checking bench for the transmit sum chain block
`timescale 1ns/1ps
module test_tx_sum_chain_scale_power_meter import tsc_pkg::*; ;
  localparam int NCH = 4;
  localparam int LEN = 200;
  localparam int REP = 250;
  typedef struct packed {
    logic [20:0] v;
    logic [2:0]  n;
    logic [3:0]  en;
    logic [3:0]  scl;
    logic [1:0]  rnd;
    logic [17:0] ex;
  } tsc_row_t;
  logic             ref_clk_i;
  logic             reset_i;
  logic             ch_valid_i;
  logic             ch_ready_o;
  tsc_ch_t          ch_a_i [NCH];
  tsc_ch_t          ch_b_i [NCH];
  logic [3:0]       en_a [NCH];
  logic [3:0]       en_b [NCH];
  logic             dual;
  logic [3:0]       scl [NCHAIN];
  logic [1:0]       rnd;
  logic             out_valid;
  logic             out_ready;
  tsc_frame_t       out_data;
  logic [3:0]       pins;
  logic             tc;
  logic             shot;
  logic [2:0]       ssel [NCHAIN];
  logic [8:0]       dly [NCHAIN];
  logic [15:0]      ilo [NCHAIN], rlo [NCHAIN], res_lo [NCHAIN], res_hi [NCHAIN];
  logic [4:0]       ihi [NCHAIN], rhi [NCHAIN];
  logic [3:0]       done;
  logic [3:0]       seen = 4'h0;
  logic [5:0]       flags;
  logic             stall;
  logic             take;
  tsc_frame_t       word;
  int               failures = 0;
  int               checked = 0;
  int               t;
  int               acc;
  // Value, channels used, chain enables, window, rounding, expected sample
  tsc_row_t rows [9] = '{
    '{21'h000100, 3'h4, 4'h1, 4'h0, 2'h0, 18'h00004},
    '{21'h000100, 3'h1, 4'h8, 4'h8, 2'h1, 18'h00100},
    '{21'h0FFFFF, 3'h4, 4'hF, 4'h8, 2'h0, 18'h1FFFF},
    '{21'h100000, 3'h4, 4'h5, 4'h8, 2'h3, 18'h20000},
    '{21'h000020, 3'h1, 4'h3, 4'h8, 2'h3, 18'h00040},
    '{21'h000008, 3'h1, 4'h6, 4'h8, 2'h2, 18'h00010},
    '{21'h01FFFF, 3'h1, 4'h9, 4'h8, 2'h1, 18'h1FFFC},
    '{21'h1FF000, 3'h2, 4'hC, 4'h4, 2'h0, 18'h3FE00},
    '{21'h000064, 3'h0, 4'hF, 4'h0, 2'h0, 18'h00000}};

  tsc_top #(.NUM_CH(NCH), .DEPTH(FIFO_DEPTH)) u_tsc_top (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .ch_valid_i(ch_valid_i), .ch_a_i(ch_a_i), .ch_b_i(ch_b_i),
    .ch_ready_o(ch_ready_o), .path_a_sum_en_i(en_a), .path_b_sum_en_i(en_b), .dual_path_mode_i(dual),
    .scale_sel_i(scl), .round_sel_i(rnd), .out_valid_o(out_valid), .out_data_o(out_data),
    .out_ready_i(out_ready), .tx_sync_pin_i(pins), .sync_count_tc_i(tc), .sync_oneshot_i(shot),
    .meter_sync_sel_i(ssel), .meter_start_delay_i(dly), .meter_integ_len_low_i(ilo),
    .meter_integ_len_high_i(ihi), .meter_repeat_low_i(rlo), .meter_repeat_high_i(rhi),
    .meter_result_low_o(res_lo), .meter_result_high_o(res_hi), .meter_done_o(done));

  tsc_sink_model u_tsc_sink_model (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .out_valid_i(out_valid), .out_data_i(out_data),
    .out_ready_o(out_ready), .stall_i(stall), .take_o(take), .word_o(word));

  // Clock, flags to wait on, and a record of which meters ever finished
  always #5 ref_clk_i = ~ref_clk_i;
  assign flags = {ch_ready_o, take, done};
  always @(posedge ref_clk_i) seen <= seen | done;

  task automatic print_verdict;
    if (failures == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // Four-state compare, so an unknown never passes
  task automatic check(input logic [35:0] got, input logic [35:0] want);
    checked++;
    if (got !== want) begin
      failures++;
      $display("[FAIL] %0t got %h want %h", $time, got, want);
    end
  endtask : check

  // Bounded wait on one flag; running out ends the run
  task automatic wait_flag(input int k, output int n);
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (flags[k] !== 1'b1 && n < 400);
    if (n >= 400) begin
      failures++;
      print_verdict();
    end
  endtask : wait_flag

  // Lowest n channels carry v on I and Q; keeping them contiguous keeps the chain whole
  task automatic put(input logic [20:0] v, input int n, input logic [3:0] en);
    for (int k = 0; k < NCH; k++) begin
      ch_a_i[k] <= (k < n) ? {v, v} : 42'h0;
      en_a[k]   <= (k < n) ? en : 4'h0;
    end
  endtask : put

  task automatic cfg(input logic [3:0] s, input logic [1:0] r);
    for (int c = 0; c < NCHAIN; c++) scl[c] <= s;
    rnd <= r;
  endtask : cfg

  // One sample in, held until ready is seen high at an edge
  task automatic send(input logic [20:0] v, input int n, input logic [3:0] en);
    int w;
    put(v, n, en);
    ch_valid_i <= 1'b1;
    wait_flag(5, w);
    ch_valid_i <= 1'b0;
  endtask : send

  // Next word taken by the sink; enabled chains carry ex on I and Q
  task automatic recv(input logic [3:0] en, input logic [17:0] ex);
    int w;
    wait_flag(4, w);
    for (int c = 0; c < NCHAIN; c++) check(word[c], en[c] ? {ex, ex} : 36'h0);
  endtask : recv

  initial begin
    ref_clk_i  = 1'b0;
    reset_i    = 1'b1;
    ch_valid_i = 1'b0;
    dual       = 1'b0;
    rnd        = 2'h0;
    stall      = 1'b0;
    pins       = 4'h0;
    tc         = 1'b0;
    shot       = 1'b0;
    ssel       = '{SYNC_SW, SYNC_ON, SYNC_OFF, 3'h0};
    for (int k = 0; k < NCH; k++) begin
      ch_a_i[k] = '0;
      ch_b_i[k] = (k == 0) ? {21'h000040, 21'h000040} : 42'h0;
      en_a[k]   = 4'h0;
      en_b[k]   = (k == 0) ? 4'h1 : 4'h0;
    end
    for (int c = 0; c < NCHAIN; c++) begin
      scl[c] = 4'h0;
      dly[c] = 9'h003;
      ilo[c] = 16'(LEN);
      ihi[c] = 5'h00;
      rlo[c] = 16'(REP);
      rhi[c] = 5'h00;
    end
    // Reset: outputs quiet while it is held
    @(posedge ref_clk_i);
    check(36'({out_valid, ch_ready_o, done, res_lo[0]}), 36'h0);
    @(posedge ref_clk_i);
    reset_i <= 1'b0;
    // Table of sums, windows and rounding; path B stays out while not in dual mode
    foreach (rows[r]) begin
      cfg(rows[r].scl, rows[r].rnd);
      send(rows[r].v, int'(rows[r].n), rows[r].en);
      recv(rows[r].en, rows[r].ex);
    end
    // Path B joins chain 0 only in dual mode
    cfg(4'h8, 2'h0);
    dual <= 1'b1;
    send(21'h000000, 0, 4'h0);
    recv(4'h1, 18'h00040);
    dual <= 1'b0;
    // Stalled sink: the buffer fills and refuses, then drains in order
    stall      <= 1'b1;
    ch_valid_i <= 1'b1;
    acc = 0;
    repeat (40) begin
      @(posedge ref_clk_i);
      if (ch_ready_o === 1'b1) acc++;
      put(21'(acc), 1, 4'h1);
    end
    // The FIFO output register holds one word beyond the stored depth
    check(36'(acc), 36'(FIFO_DEPTH + 1));
    ch_valid_i <= 1'b0;
    stall      <= 1'b0;
    for (int k = 0; k <= FIFO_DEPTH; k++) recv(4'h1, 18'(k));
    repeat (3) @(posedge ref_clk_i);
    check(36'(out_valid), 36'h0);
    // Meters on a steady full-scale stream, started by one-shot and by a pin
    put(21'h01FFFF, 1, 4'hF);
    ch_valid_i <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    shot <= 1'b1;
    pins <= 4'h1;
    @(posedge ref_clk_i);
    shot <= 1'b0;
    pins <= 4'h0;
    wait_flag(0, t);
    check(36'(res_lo[0]), 36'h08FFE);
    check(36'(res_hi[0]), 36'h00001);
    put(21'h010000, 1, 4'hF);
    @(posedge ref_clk_i);
    check(36'(done[0]), 36'h0);
    repeat (REP - 2) @(posedge ref_clk_i);
    check(36'(res_lo[0]), 36'h08FFE);
    wait_flag(0, t);
    check(36'(t), 36'h2);
    check(36'({res_hi[0], res_lo[0]}), 36'h000006400);
    check(36'(seen), 36'hB);
    // Counter terminal count as the sync of meter 2
    ssel[2] <= SYNC_TC;
    @(posedge ref_clk_i);
    tc <= 1'b1;
    @(posedge ref_clk_i);
    tc <= 1'b0;
    wait_flag(2, t);
    check(36'(res_lo[2]), 36'h06400);
    // Reset in mid-stream clears the stream and the results
    reset_i <= 1'b1;
    @(posedge ref_clk_i);
    check(36'({out_valid, ch_ready_o, done, res_lo[0]}), 36'h0);
    print_verdict();
  end
endmodule : test_tx_sum_chain_scale_power_meter
